// ---- verilog/clk_sleep_pkg.sv ----
// Constants for the clock prescaler and sleep controller.
// Assumes a single 10 MHz undivided clock and a simple strobe register port.
// What this block does
// [RULE_01] Divider fields change only while unlock is set
// [RULE_02] Unlock updates only when other bits zero
// [RULE_03] Unlock clears after four cycles or field write
// [RULE_04] Rewriting unlock keeps the original expiry
// [RULE_05] Prescaler bit six always reads zero
// [RULE_06] Timer code zero disables, else 2^(n-1)
// [RULE_07] System clock divided by two to code
// [RULE_08] Fuse selects reset value 000 or 011
// [RULE_09] Any system code writable regardless of fuse
// [RULE_10] Sleep only when sleep instruction meets arm
// [RULE_11] Mode codes idle, noise, power-down; rest reserved
// [RULE_12] Interrupt wake holds core four extra cycles
// [RULE_13] Register file and SRAM kept across sleep
// [RULE_14] Reset during sleep restarts from reset vector
// [RULE_15] Software arms just before sleep, clears after
// [RULE_16] Idle stops only CPU and flash clocks
// [RULE_17] Noise mode stops CPU, flash, I/O clocks
// [RULE_18] Noise mode timers 2/3 wake if enabled
// [RULE_19] Power-down stops oscillators, brown-out unless kept
// [RULE_20] Power-down wakes only on listed sources
// [RULE_21] Power-down keeps only slow RC clock
// [RULE_22] Power-down wake waits fuse-selected start-up time
// [RULE_23] Software unlocks then writes within four cycles
// [RULE_24] Divider switch is glitch free, no overshoot
// [RULE_25] Deep modes wake only on level interrupts
// [RULE_26] Reserved mode codes behave as idle
`default_nettype none
package clk_sleep_pkg;
    localparam logic [3:0] ADDR_DIV = 4'h0;
    localparam logic [3:0] ADDR_SLEEP = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam int UNLOCK_BIT = 7;
    localparam int RSVD_BIT = 6;
    localparam int TDIV_LSB = 3;
    localparam int SDIV_LSB = 0;
    localparam logic [7:0] UNLOCK_ONLY = 8'h80;
    localparam logic [2:0] SDIV_RESET_PLAIN = 3'h0;
    localparam logic [2:0] SDIV_RESET_FUSE = 3'h3;
    localparam logic [2:0] TDIV_OFF = 3'h0;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic [2:0] WAKE_HOLD_CYCLES = 3'h4;
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_NOISE = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam int CLK_HZ = 10_000_000;
    // Start-up periods per fuse code in microseconds
    localparam int STARTUP_US_0 = 10;
    localparam int STARTUP_US_1 = 100;
    localparam int STARTUP_US_2 = 1000;
    localparam int STARTUP_US_3 = 4000;
    localparam int US_CYC = CLK_HZ / 1_000_000;
    localparam logic [15:0] STARTUP_CYC_0 = 16'(STARTUP_US_0 * US_CYC);
    localparam logic [15:0] STARTUP_CYC_1 = 16'(STARTUP_US_1 * US_CYC);
    localparam logic [15:0] STARTUP_CYC_2 = 16'(STARTUP_US_2 * US_CYC);
    localparam logic [15:0] STARTUP_CYC_3 = 16'(STARTUP_US_3 * US_CYC);
    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_SLEEP = 4'b0010,
        ST_START = 4'b0100,
        ST_HOLD = 4'b1000
    } sleep_state_t;
endpackage : clk_sleep_pkg
`default_nettype wire

// ---- verilog/glitchless_div.sv ----
// Glitch-free power-of-two clock enable divider.
// Assumes the code input is stable from the same clock domain.
`default_nettype none
module glitchless_div #(
    parameter int W = 7
) (
    input wire logic clk_i, // Undivided clock
    input wire logic reset_i, // Async reset
    input wire logic run_i, // Divider allowed to tick
    input wire logic [2:0] shift_i, // Divide by 2^shift
    output logic tick_o // One-cycle divided enable
);
    logic [W-1:0] cnt_q;
    logic [2:0] shift_q;
    logic [W-1:0] mask;
    // New setting is adopted only at a period boundary or while stopped, so no short period
    always_comb begin
        mask = W'((1 << shift_q) - 1);
    end
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            shift_q <= 3'h0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q <= '0;
            tick_o <= 1'b0;
            shift_q <= shift_i;
        end else if ((cnt_q & mask) == mask) begin // [RULE_24]
            cnt_q <= '0;
            tick_o <= 1'b1;
            shift_q <= shift_i;
        end else begin
            cnt_q <= cnt_q + W'(1);
            tick_o <= 1'b0;
        end
    end
endmodule : glitchless_div
`default_nettype wire

// ---- verilog/clock_prescaler_sleep_ctrl.sv ----
// Prescaler register with timed unlock plus sleep/wake clock gating control.
// Assumes core strobes are synchronous; wake sources and fuses come from pins.
//
// Design decisions made here: the strobed register port and the register addresses.
`default_nettype none
module clock_prescaler_sleep_ctrl
    import clk_sleep_pkg::*;
(
    input wire logic clk_i, // Undivided input clock
    input wire logic reset_i, // Chip reset, async high
    input wire logic [3:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after strobe
    input wire logic sleep_instr_i, // Core executes sleep instruction
    input wire logic div8_fuse_i, // Divide-by-eight fuse programmed
    input wire logic [1:0] startup_time_fuses_i, // Start-up period select
    input wire logic brown_out_keep_alive_i, // Keep brown-out in power-down
    input wire logic slow_rc_enable_i, // Slow RC clock enabled
    input wire logic global_irq_en_i, // Global interrupt enable
    input wire logic irq_internal_i, // Any enabled internal interrupt
    input wire logic timer23_irq_i, // Timer 2/3 event, masked
    input wire logic ext_level_irq_i, // Level interrupt on either line
    input wire logic ext_edge_irq_i, // Edge interrupt on either line
    input wire logic pin_change_irq_i, // Pin-change interrupt
    input wire logic lf_start_irq_i, // LF receiver start condition
    output logic cpu_clk_en_o, // CPU clock enable
    output logic flash_clk_en_o, // Flash clock enable
    output logic io_clk_en_o, // I/O clock enable
    output logic timer_clk_en_o, // Divided timer clock enable
    output logic sys_tick_o, // Divided system clock tick
    output logic fast_rc_run_o, // Fast RC oscillator on
    output logic ext_clk_run_o, // External clock inputs on
    output logic brown_out_run_o, // Voltage monitor and brown-out on
    output logic slow_rc_run_o, // Slow RC clock on
    output logic core_hold_o, // Core held, no fetch
    output logic wake_irq_o, // Resume into interrupt handler
    output logic sleeping_o // Block is in a sleep mode
);
    logic [2:0] tdiv_q, sdiv_q, mode_q;
    logic unlock_q, arm_q;
    logic [2:0] unlock_cnt_q;
    logic [15:0] start_cnt_q;
    logic [2:0] hold_cnt_q;
    sleep_state_t state_q;
    logic [1:0] fuse_s1_q, fuse_s2_q;
    logic [5:0] wake_s1_q, wake_s2_q;
    logic div8_s1_q, div8_s2_q;
    logic boot_q;
    logic wr_div, wr_fields, wake_any;
    logic [15:0] startup_cyc;
    logic t_tick, s_tick, t_run, s_run;
    logic [2:0] t_shift;
    logic [5:0] wake_raw;

    // Wake and start-up fuse pins pass two flops before any logic reads them
    assign wake_raw = {timer23_irq_i, ext_level_irq_i, ext_edge_irq_i,
                       pin_change_irq_i, lf_start_irq_i, irq_internal_i};
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_s1_q <= '0;
            wake_s2_q <= '0;
            fuse_s1_q <= '0;
            fuse_s2_q <= '0;
        end else begin
            wake_s1_q <= wake_raw;
            wake_s2_q <= wake_s1_q;
            fuse_s1_q <= startup_time_fuses_i;
            fuse_s2_q <= fuse_s1_q;
        end
    end

    // Fuse synchroniser has no reset, so the fuse level is through it at reset release
    always_ff @(posedge clk_i) begin
        div8_s1_q <= div8_fuse_i;
        div8_s2_q <= div8_s1_q;
    end

    assign wr_div = wr_i && addr_i == ADDR_DIV;
    // A write carrying unlock zero touches the fields
    assign wr_fields = wr_div && !wdata_i[UNLOCK_BIT];

    // Unlock bit with fixed four-cycle window
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            unlock_q <= 1'b0;
            unlock_cnt_q <= 3'h0;
        end else if (unlock_q && (wr_fields || unlock_cnt_q == UNLOCK_CYCLES - 3'h1)) begin
            unlock_q <= 1'b0; // [RULE_03]
            unlock_cnt_q <= 3'h0;
        end else if (unlock_q) begin
            unlock_cnt_q <= unlock_cnt_q + 3'h1; // [RULE_04]
        end else if (wr_div && wdata_i == UNLOCK_ONLY) begin
            unlock_q <= 1'b1; // [RULE_02]
            unlock_cnt_q <= 3'h0;
        end
    end

    // Fuse caught once after reset release, since async reset takes constants only
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            boot_q <= 1'b1;
            tdiv_q <= TDIV_OFF;
            sdiv_q <= SDIV_RESET_PLAIN;
        end else if (boot_q) begin
            boot_q <= 1'b0;
            sdiv_q <= div8_s2_q ? SDIV_RESET_FUSE : SDIV_RESET_PLAIN; // [RULE_08]
        end else if (wr_fields && unlock_q) begin // [RULE_01]
            tdiv_q <= wdata_i[TDIV_LSB +: 3];
            sdiv_q <= wdata_i[SDIV_LSB +: 3]; // [RULE_09]
        end
    end

    // Sleep control register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            arm_q <= 1'b0;
            mode_q <= MODE_IDLE;
        end else if (wr_i && addr_i == ADDR_SLEEP) begin
            arm_q <= wdata_i[0];
            mode_q <= wdata_i[3:1];
        end
    end

    // Wake sources allowed per mode
    always_comb begin
        unique case (mode_q)
            MODE_NOISE: wake_any = wake_s2_q[0] || wake_s2_q[1] || wake_s2_q[2]
                                   || wake_s2_q[4] || (wake_s2_q[5] && global_irq_en_i); // [RULE_18] [RULE_25]
            MODE_PDOWN: wake_any = wake_s2_q[1] || wake_s2_q[2] || wake_s2_q[4]; // [RULE_20] [RULE_25]
            default: wake_any = |wake_s2_q[5:0]; // [RULE_16] [RULE_26]
        endcase
    end

    always_comb begin
        unique case (fuse_s2_q)
            2'h0: startup_cyc = STARTUP_CYC_0;
            2'h1: startup_cyc = STARTUP_CYC_1;
            2'h2: startup_cyc = STARTUP_CYC_2;
            default: startup_cyc = STARTUP_CYC_3;
        endcase
    end

    // Sleep sequencer; reset from any state returns to run via the vector [RULE_14]
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= ST_RUN;
            start_cnt_q <= '0;
            hold_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_RUN: if (sleep_instr_i && arm_q) begin // [RULE_10]
                    state_q <= ST_SLEEP;
                end
                ST_SLEEP: if (wake_any) begin
                    // Only power-down stops the oscillator, so only it waits start-up
                    state_q <= (mode_q == MODE_PDOWN) ? ST_START : ST_HOLD; // [RULE_22]
                    start_cnt_q <= '0;
                    hold_cnt_q <= '0;
                end
                ST_START: if (start_cnt_q >= startup_cyc - 16'h1) begin
                    state_q <= ST_HOLD;
                end else begin
                    start_cnt_q <= start_cnt_q + 16'h1;
                end
                ST_HOLD: if (hold_cnt_q == WAKE_HOLD_CYCLES - 3'h1) begin
                    state_q <= ST_RUN; // [RULE_12]
                end else begin
                    hold_cnt_q <= hold_cnt_q + 3'h1;
                end
                default: state_q <= ST_RUN;
            endcase
        end
    end

    // Dividers run only while their clock domain is live
    assign s_run = state_q == ST_RUN || state_q == ST_HOLD;
    assign t_run = tdiv_q != TDIV_OFF && !(state_q == ST_SLEEP && mode_q == MODE_PDOWN);
    assign t_shift = tdiv_q - 3'h1; // [RULE_06]
    glitchless_div #(.W(7)) u_sys_div (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(s_run),
        .shift_i(sdiv_q), // [RULE_07]
        .tick_o(s_tick)
    );
    glitchless_div #(.W(7)) u_tim_div (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .run_i(t_run),
        .shift_i(t_shift),
        .tick_o(t_tick)
    );

    // Clock gating outputs per mode; no state is cleared so memories keep contents [RULE_13]
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cpu_clk_en_o <= 1'b1;
            flash_clk_en_o <= 1'b1;
            io_clk_en_o <= 1'b1;
            fast_rc_run_o <= 1'b1;
            ext_clk_run_o <= 1'b1;
            brown_out_run_o <= 1'b1;
            slow_rc_run_o <= 1'b1;
        end else begin
            cpu_clk_en_o <= state_q == ST_RUN; // [RULE_16]
            flash_clk_en_o <= state_q == ST_RUN;
            io_clk_en_o <= !(state_q == ST_SLEEP && (mode_q == MODE_NOISE || mode_q == MODE_PDOWN)); // [RULE_17]
            fast_rc_run_o <= !(state_q == ST_SLEEP && mode_q == MODE_PDOWN); // [RULE_19] [RULE_21]
            ext_clk_run_o <= !(state_q == ST_SLEEP && mode_q == MODE_PDOWN);
            brown_out_run_o <= !(state_q == ST_SLEEP && mode_q == MODE_PDOWN) || brown_out_keep_alive_i;
            slow_rc_run_o <= slow_rc_enable_i;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_clk_en_o <= 1'b0;
            sys_tick_o <= 1'b0;
            core_hold_o <= 1'b0;
            wake_irq_o <= 1'b0;
            sleeping_o <= 1'b0;
        end else begin
            timer_clk_en_o <= t_tick;
            sys_tick_o <= s_tick;
            core_hold_o <= state_q != ST_RUN;
            wake_irq_o <= state_q == ST_HOLD && hold_cnt_q == WAKE_HOLD_CYCLES - 3'h1;
            sleeping_o <= state_q == ST_SLEEP;
        end
    end

    // Read data, one cycle after strobe
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            unique case (addr_i)
                ADDR_DIV: rdata_o <= {unlock_q, 1'b0, tdiv_q, sdiv_q}; // [RULE_05]
                ADDR_SLEEP: rdata_o <= {4'h0, mode_q, arm_q}; // [RULE_11]
                ADDR_STATUS: rdata_o <= {4'h0, state_q};
                default: rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // A window never outlives four cycles, nor survives a field write
    chk_unlock_expiry: assert property (@(posedge clk_i) disable iff (reset_i)
        unlock_q [*4] |=> !unlock_q) // [RULE_03]
        else $error("unlock window longer than four cycles");
    chk_unlock_field: assert property (@(posedge clk_i) disable iff (reset_i)
        (unlock_q && wr_fields) |=> !unlock_q) // [RULE_03]
        else $error("unlock kept after field write");
    chk_field_locked: assert property (@(posedge clk_i) disable iff (reset_i)
        (!unlock_q && !boot_q) |=> $stable(tdiv_q)) // [RULE_01]
        else $error("divider changed while locked");
    chk_sleep_armed: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == ST_RUN && !(sleep_instr_i && arm_q)) |=> state_q == ST_RUN) // [RULE_10]
        else $error("sleep without arm");
    chk_wake_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(state_q == ST_HOLD) |-> (state_q == ST_HOLD) [*4] ##1 state_q == ST_RUN) // [RULE_12]
        else $error("wake hold not four cycles");
    chk_idle_io: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == ST_SLEEP && mode_q == MODE_IDLE) |=> io_clk_en_o && !cpu_clk_en_o) // [RULE_16]
        else $error("idle gating wrong");
    chk_noise_io: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == ST_SLEEP && mode_q == MODE_NOISE) |=> !io_clk_en_o && fast_rc_run_o) // [RULE_17]
        else $error("noise gating wrong");
    chk_pdown_osc: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == ST_SLEEP && mode_q == MODE_PDOWN) |=> !fast_rc_run_o && !ext_clk_run_o) // [RULE_19]
        else $error("power-down oscillator running");
    chk_pdown_edge: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == ST_SLEEP && mode_q == MODE_PDOWN && wake_s2_q[3:2] == 2'b10
         && !wake_s2_q[4] && !wake_s2_q[1]) |=> state_q == ST_SLEEP) // [RULE_25]
        else $error("edge interrupt woke power-down");
    chk_rsvd_read: assert property (@(posedge clk_i) disable iff (reset_i)
        $past(rd_i) |-> !rdata_o[RSVD_BIT]) // [RULE_05]
        else $error("reserved bit read as one");
    chk_bo_keep: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_q == ST_SLEEP && mode_q == MODE_PDOWN && brown_out_keep_alive_i) |=> brown_out_run_o) // [RULE_19]
        else $error("brown-out stopped despite keep-alive");
    cov_unlock_write: cover property (@(posedge clk_i) disable iff (reset_i) unlock_q && wr_fields);
    cov_pdown_wake: cover property (@(posedge clk_i) disable iff (reset_i)
        state_q == ST_START ##1 state_q == ST_HOLD);
    cov_idle_wake: cover property (@(posedge clk_i) disable iff (reset_i)
        state_q == ST_SLEEP && mode_q == MODE_IDLE ##1 state_q == ST_HOLD);
    cov_noise_wake: cover property (@(posedge clk_i) disable iff (reset_i)
        state_q == ST_SLEEP && mode_q == MODE_NOISE ##1 state_q == ST_HOLD);
    cov_rsvd_sleep: cover property (@(posedge clk_i) disable iff (reset_i)
        state_q == ST_SLEEP && mode_q > MODE_PDOWN);
endmodule : clock_prescaler_sleep_ctrl
`default_nettype wire

// ---- testbench/core_model.sv ----
// Processor core model: register strobes and the sleep instruction.
// Assumes one clock; every request changes just after a rising edge.
`default_nettype none
module core_model
    import clk_sleep_pkg::*;
(
    input wire logic clk_i, // Core clock
    input wire logic [7:0] rdata_i, // Read data
    output logic [3:0] addr_o, // Address
    output logic [7:0] wdata_o, // Write data
    output logic wr_o, // Write strobe
    output logic rd_o, // Read strobe
    output logic sleep_instr_o // Sleep instruction
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet bus at time zero
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        sleep_instr_o = 1'b0;
    end
    // Data inverted on release so a stale byte never looks valid
    task automatic write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : write
    // Data taken in the one cycle that it stands
    task automatic read(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask : read
    // Unlock, then field write two cycles later
    task automatic set_divider(input logic [7:0] d);
        write(ADDR_DIV, UNLOCK_ONLY);
        write(ADDR_DIV, d);
    endtask : set_divider
    // Arm right before the instruction; the caller disarms after wake
    task automatic exec_sleep(input logic [2:0] mode, input logic arm);
        write(ADDR_SLEEP, {4'h0, mode, arm});
        @(posedge clk_i);
        sleep_instr_o <= 1'b1;
        @(posedge clk_i);
        sleep_instr_o <= 1'b0;
    endtask : exec_sleep
endmodule : core_model
`default_nettype wire

// ---- testbench/clock_prescaler_sleep_ctrl_tb.sv ----
// Self-checking bench for the prescaler and sleep controller.
// Assumes the core model drives the register port and sleep pulse.
`default_nettype none
module clock_prescaler_sleep_ctrl_tb;
    import clk_sleep_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] w; logic [7:0] r; int sp; int tp;} div_row_t;
    typedef struct {logic [2:0] m; logic [7:0] en; logic [5:0] bad; logic [5:0] good; int lo; int hi;} slp_row_t;
    // Written byte, read-back, system and timer tick spacing (0 = none)
    div_row_t div_rows [8] = '{'{8'h00, 8'h00, 1, 0}, '{8'h0f, 8'h0f, 128, 1}, '{8'h56, 8'h16, 64, 2},
        '{8'h1d, 8'h1d, 32, 4}, '{8'h24, 8'h24, 16, 8}, '{8'h2b, 8'h2b, 8, 16}, '{8'h72, 8'h32, 4, 32},
        '{8'h39, 8'h39, 2, 64}};
    // Mode, enables, non-waking and waking sources, wake delay window
    slp_row_t slp_rows [4] = '{'{MODE_IDLE, 8'h3f, 6'h00, 6'h20, 4, 12}, '{MODE_NOISE, 8'h1f, 6'h04, 6'h10, 4, 12},
        '{MODE_PDOWN, 8'h03, 6'h24, 6'h02, 104, 116}, '{3'h5, 8'h3f, 6'h00, 6'h04, 4, 12}};
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] rv;
    logic wr, rd, sleep_instr, cpu_en, flash_en, io_en, tim_en, sys_tick, fast_rc, ext_clk;
    logic bo_run, slow_rc, core_hold, wake_irq, sleeping;
    logic div8_fuse = 1'b0;
    logic gie = 1'b1;
    logic keep_bo = 1'b0;
    logic slow_en = 1'b1;
    logic [1:0] sut = 2'b00;
    logic [5:0] irq_v = 6'h00; // internal, timer, level, edge, pin, lf
    int bad_count = 0;
    int samples_checked = 0;
    int p;
    int n;
    always #50 clk_i = ~clk_i;
    core_model u_core (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .sleep_instr_o(sleep_instr));
    clock_prescaler_sleep_ctrl u_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sleep_instr_i(sleep_instr), .div8_fuse_i(div8_fuse),
        .startup_time_fuses_i(sut), .brown_out_keep_alive_i(keep_bo), .slow_rc_enable_i(slow_en),
        .global_irq_en_i(gie), .irq_internal_i(irq_v[5]), .timer23_irq_i(irq_v[4]), .ext_level_irq_i(irq_v[3]),
        .ext_edge_irq_i(irq_v[2]), .pin_change_irq_i(irq_v[1]), .lf_start_irq_i(irq_v[0]),
        .cpu_clk_en_o(cpu_en), .flash_clk_en_o(flash_en), .io_clk_en_o(io_en), .timer_clk_en_o(tim_en),
        .sys_tick_o(sys_tick), .fast_rc_run_o(fast_rc), .ext_clk_run_o(ext_clk), .brown_out_run_o(bo_run),
        .slow_rc_run_o(slow_rc), .core_hold_o(core_hold), .wake_irq_o(wake_irq), .sleeping_o(sleeping));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Spacing of the third tick; the first ones may be in a switch-over
    task automatic period(input bit tim, output int q);
        int hits;
        int last;
        q = 0;
        hits = 0;
        last = 0;
        for (int k = 0; k < 450 && hits < 3; k++) begin
            @(posedge clk_i);
            #1;
            if ((tim ? tim_en : sys_tick) === 1'b1) begin
                hits++;
                q = k - last;
                last = k;
            end
        end
        if (hits < 3) q = 0;
    endtask : period
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // Watchdog sized well above the roughly 3000 cycles of the tests
    initial begin
        #3_000_000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        u_core.read(ADDR_DIV, rv);
        check("div_reset", 8'h00, rv);
        u_core.read(4'hf, rv);
        check("unmapped", 8'h00, rv);
        foreach (div_rows[i]) begin
            u_core.set_divider(div_rows[i].w);
            u_core.read(ADDR_DIV, rv);
            check("div_read", div_rows[i].r, rv);
            period(1'b0, p);
            check("sys_period", 16'(div_rows[i].sp), 16'(p));
            period(1'b1, p);
            check("tim_period", 16'(div_rows[i].tp), 16'(p));
        end
        // Unlock refused when other bits are set, then a bare field write
        u_core.write(ADDR_DIV, 8'h81);
        u_core.write(ADDR_DIV, 8'h05);
        u_core.read(ADDR_DIV, rv);
        check("unlock_needs_zeros", 8'h39, rv);
        // Window seen open, then lapsed, then a late field write
        u_core.write(ADDR_DIV, UNLOCK_ONLY);
        u_core.read(ADDR_DIV, rv);
        check("unlock_open", 8'hb9, rv);
        @(posedge clk_i);
        u_core.read(ADDR_DIV, rv);
        check("unlock_lapsed", 8'h39, rv);
        u_core.write(ADDR_DIV, 8'h05);
        u_core.read(ADDR_DIV, rv);
        check("late_write", 8'h39, rv);
        // Second unlock mid-window must not push the expiry back
        u_core.write(ADDR_DIV, UNLOCK_ONLY);
        u_core.write(ADDR_DIV, UNLOCK_ONLY);
        @(posedge clk_i);
        u_core.write(ADDR_DIV, 8'h05);
        u_core.read(ADDR_DIV, rv);
        check("no_restart", 8'h39, rv);
        u_core.write(ADDR_SLEEP, 8'hf5);
        u_core.read(ADDR_SLEEP, rv);
        check("sleep_reg", 8'h05, rv);
        u_core.exec_sleep(MODE_IDLE, 1'b0);
        repeat (4) @(posedge clk_i);
        #1;
        check("unarmed", 1'b0, sleeping);
        foreach (slp_rows[i]) begin
            u_core.exec_sleep(slp_rows[i].m, 1'b1);
            repeat (4) @(posedge clk_i);
            #1;
            check("gating", slp_rows[i].en,
                {cpu_en, flash_en, io_en, fast_rc, ext_clk, bo_run, slow_rc, sleeping});
            irq_v <= slp_rows[i].bad;
            repeat (20) @(posedge clk_i);
            #1;
            check("no_wake", 1'b1, sleeping);
            irq_v <= slp_rows[i].good;
            n = 0;
            while (wake_irq !== 1'b1 && n < 200) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            check("wake_delay", 1'b1, n >= slp_rows[i].lo && n <= slp_rows[i].hi);
            irq_v <= 6'h00;
            u_core.write(ADDR_SLEEP, 8'h00);
            repeat (4) @(posedge clk_i);
            #1;
            check("awake", 4'b1100, {cpu_en, io_en, core_hold, sleeping});
        end
        // Timer wake needs the global enable; then a slow-start power-down with keep-alive
        gie <= 1'b0;
        keep_bo <= 1'b1;
        slow_en <= 1'b0;
        sut <= 2'b01;
        u_core.exec_sleep(MODE_NOISE, 1'b1);
        irq_v <= 6'h10;
        repeat (20) @(posedge clk_i);
        #1;
        check("gie_off", 1'b1, sleeping);
        gie <= 1'b1;
        repeat (20) @(posedge clk_i);
        #1;
        check("gie_on", 1'b0, sleeping);
        irq_v <= 6'h00;
        u_core.exec_sleep(MODE_PDOWN, 1'b1);
        repeat (4) @(posedge clk_i);
        #1;
        check("keep_alive", 3'b101, {bo_run, slow_rc, sleeping});
        irq_v <= 6'h02;
        repeat (1000) @(posedge clk_i);
        #1;
        check("slow_start", 2'b10, {core_hold, sleeping});
        repeat (10) @(posedge clk_i);
        #1;
        check("slow_started", 2'b00, {core_hold, sleeping});
        irq_v <= 6'h00;
        sut <= 2'b00;
        // Reset in power-down with the divide-by-eight fuse programmed
        div8_fuse <= 1'b1;
        u_core.exec_sleep(MODE_PDOWN, 1'b1);
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        check("reset_wake", 2'b10, {cpu_en, sleeping});
        u_core.read(ADDR_DIV, rv);
        check("fuse_reset", 8'h03, rv);
        u_core.set_divider(8'h00);
        u_core.read(ADDR_DIV, rv);
        check("fuse_override", 8'h00, rv);
        report_and_stop();
    end
endmodule : clock_prescaler_sleep_ctrl_tb
`default_nettype wire
